// File: quart_pkg.sv
// Purpose: Shared constants for the quad UART host bus port and its controller
// Assumes: One clock, pclk at 100 MHz
// Notes: Register offsets are APB byte addresses of the controller
package quart_pkg;
  localparam int CHANNELS = 4;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int SRC_PER_CHAN = 4;
  localparam int SYNC_W = 8;
  // Bit positions inside the synchronised control vector
  localparam int SY_STYLE = 0;
  localparam int SY_SEL = 1;
  localparam int SY_WR = 5;
  localparam int SY_RD = 6;
  localparam int SY_RDY = 7;
  localparam logic STYLE_SEPARATE = 1'b1;
  localparam logic IRQ_N_LEVEL = 1'b0;
  localparam logic [7:0] BUS_FLOAT = 8'hFF;
  // Bus timing of the controller, in ns, turned into pclk cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_NS = 40;
  localparam int ACTION_NS = 80;
  localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTION_CYC = (ACTION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Controller registers
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_CHAN_LSB = 3;
  localparam int CMD_WRITE = 5;
  localparam int CMD_SUMMARY = 6;
  localparam int CMD_DATA_LSB = 8;
  localparam int CFG_STYLE = 0;
  localparam int CFG_DRIVE = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DATA_LSB = 8;
  localparam int ST_IRQ_LSB = 16;
  localparam int ST_IRQ_N = 20;
  localparam int EV_DONE = 0;
  localparam int EV_DEVIRQ = 1;
  localparam int EV_W = 2;
  localparam logic [1:0] CFG_RESET = 2'h1;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
endpackage

// File: quart_bus_if.sv
// Purpose: Pin level bus between a host processor end and the quad UART port
// Assumes: Both ends clocked by the same pclk
// Notes: Resolves the three-state and open-drain wires from the enables
`timescale 1ns/1ps
`default_nettype none
interface quart_bus_if;
  logic bus_style;
  logic irq_drive_select;
  logic [3:0] chan_select_n;
  logic [1:0] channel_index_bits;
  logic [2:0] register_index_bits;
  logic host_read_n;
  logic host_write_n;
  logic ready_summary_select_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [3:0] chan_irq;
  logic [3:0] chan_irq_oe;
  logic irq_n_out;
  logic irq_n_oe;
  logic [7:0] data_bus;
  logic [3:0] chan_irq_wire;
  logic irq_n_wire;
  // Device wins only if both drive; a floating bus reads as pulled high
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : quart_pkg::BUS_FLOAT);
  assign irq_n_wire = irq_n_oe ? irq_n_out : 1'b1;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_irq
    assign chan_irq_wire[g] = chan_irq_oe[g] ? chan_irq[g] : 1'b0;
  end
  modport dev (input bus_style, irq_drive_select, chan_select_n, channel_index_bits, register_index_bits,
    host_read_n, host_write_n, ready_summary_select_n, data_bus,
    output dev_data, dev_data_oe, chan_irq, chan_irq_oe, irq_n_out, irq_n_oe);
  modport host (output bus_style, irq_drive_select, chan_select_n, channel_index_bits, register_index_bits,
    host_read_n, host_write_n, ready_summary_select_n, host_data, host_data_oe,
    input data_bus, chan_irq_wire, irq_n_wire);
endinterface
`default_nettype wire

// File: quart_dev_port.sv
// Purpose: Device end of the quad UART host bus port
// Assumes: Host pins are sampled on pclk; data and index pins settle before strobes
// Notes: Channel cores sit on the user side and answer chan_rdata by chan_reg_idx
//
// Overview of operation
// R1 - Shared select low enables all four channels
// R2 - Combined mode picks channel from index bits
// R3 - Separate mode: shared select acts as channel A
// R4 - Separate mode: per-channel selects, transfer selected only
// R5 - Summary select low drives ready summary word
// R6 - Summary: inverted tx low, inverted rx high
// R7 - Eight-bit bus, driven only during reads
// R8 - Data bit 0 is least significant
// R9 - Channel interrupt needs output enable, enable, pending
// R10 - Interrupt sources: errors, rx data, tx empty, modem
// R11 - Drive select high keeps interrupts always driven
// R12 - Drive select low: output enable bit drives
// R13 - Drive select defaults low, ignored combined mode
// R14 - Separate mode read strobe falling drives register
// R15 - Separate mode write strobe falling stores data
// R16 - Style high separate, low combined with shared line
// R17 - Combined mode: one open-drain active-low request
// R18 - Combined line falling writes, rising reads
// R19 - Synchronise strobes, act once per edge
`timescale 1ns/1ps
`default_nettype none
module quart_dev_port #(
  parameter int CHAN = 4,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  quart_bus_if.dev bus,
  output logic [CHAN-1:0] chan_wr_stb,
  output logic [CHAN-1:0] chan_rd_stb,
  output logic [2:0] chan_reg_idx,
  output logic [DW-1:0] chan_wdata,
  input wire logic [CHAN*DW-1:0] chan_rdata,
  input wire logic [CHAN-1:0] tx_space_flag,
  input wire logic [CHAN-1:0] rx_avail_flag,
  input wire logic [CHAN*4-1:0] chan_irq_cond,
  input wire logic [CHAN*4-1:0] chan_irq_enable,
  input wire logic [CHAN-1:0] chan_out_enable
);
  // The pin map and the summary word assume exactly four byte-wide channels;
  // other values are refused by the elaboration error below
  if (CHAN != quart_pkg::CHANNELS || DW != quart_pkg::DATA_W) begin : g_bad_params
    $error("quart_dev_port serves four channels of eight bits only");
  end

  logic [quart_pkg::SYNC_W-1:0] sync1_r;
  logic [quart_pkg::SYNC_W-1:0] sync2_r;
  logic [quart_pkg::SYNC_W-1:0] sync3_r;
  logic [quart_pkg::SYNC_W-1:0] pins_raw;
  logic separate;
  logic [CHAN-1:0] sel_mask;
  logic wr_event;
  logic rd_event;
  logic rd_hold;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] summary;
  logic [CHAN-1:0] irq_req;
  logic [DW-1:0] data_r;
  logic data_oe_r;
  logic [CHAN-1:0] irq_r;
  logic [CHAN-1:0] irq_oe_r;
  logic irq_n_oe_r;
  logic [2:0] idx_r;
  logic [DW-1:0] wdata_r;
  logic [CHAN-1:0] wr_stb_r;
  logic [CHAN-1:0] rd_stb_r;

  // Drive select is not in this vector; it is used straight from its pin and an undriven pin is not forced low [R13]
  assign pins_raw = {bus.ready_summary_select_n, bus.host_read_n, bus.host_write_n,
                     bus.chan_select_n, bus.bus_style};

  // Two flops per pin, third stage only feeds the edge detectors [R19]
  // Reset to ones so that the idle-high pins give no false edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // The style pin goes through the same synchroniser as the strobes, so a mode
  // change and a strobe seen in one cycle are judged by the same mode
  assign separate = (sync2_r[quart_pkg::SY_STYLE] == quart_pkg::STYLE_SEPARATE); // [R16]

  // Combined mode reads the channel index pins raw: they settle well before the
  // shared select falls, which saves two flops of latency per access
  always_comb begin
    sel_mask = '0;
    if (separate) begin
      sel_mask = ~sync2_r[quart_pkg::SY_SEL +: CHAN]; // [R3] [R4]
    end else if (!sync2_r[quart_pkg::SY_SEL]) begin
      sel_mask[bus.channel_index_bits] = 1'b1; // [R1] [R2]
    end
  end

  // Each edge is seen for exactly one cycle, so one transfer per strobe [R19]
  // Combined mode: the rising R/W edge is the read, the read strobe pin is ignored
  always_comb begin
    wr_event = sync3_r[quart_pkg::SY_WR] && !sync2_r[quart_pkg::SY_WR]; // [R15] [R18]
    if (separate) begin
      rd_event = sync3_r[quart_pkg::SY_RD] && !sync2_r[quart_pkg::SY_RD]; // [R14]
      rd_hold = !sync2_r[quart_pkg::SY_RD];
    end else begin
      rd_event = !sync3_r[quart_pkg::SY_WR] && sync2_r[quart_pkg::SY_WR]; // [R18]
      rd_hold = sync2_r[quart_pkg::SY_WR] && !sync2_r[quart_pkg::SY_SEL];
    end
  end

  // Several selects low in separate mode: the lowest channel answers a read
  always_comb begin
    rd_word = '0;
    for (int i = CHAN - 1; i >= 0; i--) begin
      if (sel_mask[i]) begin
        rd_word = chan_rdata[i*DW +: DW];
      end
    end
  end

  // Flags are active high here, so a ready channel reads as a zero bit
  assign summary = {~rx_avail_flag, ~tx_space_flag}; // [R6]

  // Index and write data follow the pins; they are stable before the strobe edge arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= '0;
      wdata_r <= '0;
    end else begin
      idx_r <= bus.register_index_bits; // [R14]
      wdata_r <= bus.data_bus; // [R8] [R15]
    end
  end

  // A strobe lasts one pclk; channel cores must take it in that cycle,
  // there is no handshake back to the port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_stb_r <= '0;
      rd_stb_r <= '0;
    end else begin
      wr_stb_r <= wr_event ? sel_mask : '0; // [R4] [R15] [R18]
      rd_stb_r <= rd_event ? sel_mask : '0; // [R14]
    end
  end

  // Data bus driver: summary has priority, reads hold until the strobe ends
  // Read data is taken when the edge is seen; channel data must be valid then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= '0;
      data_oe_r <= 1'b0;
    end else if (!sync2_r[quart_pkg::SY_RDY]) begin
      data_r <= summary; // [R5]
      data_oe_r <= 1'b1;
    end else if (rd_event && (sel_mask != '0)) begin
      data_r <= rd_word; // [R8] [R14] [R18]
      data_oe_r <= 1'b1; // [R7]
    end else if (!rd_hold) begin
      data_oe_r <= 1'b0; // [R7]
    end
  end

  genvar c;
  for (c = 0; c < CHAN; c++) begin : g_chan
    // Sources per channel: receiver errors, rx data, tx empty, modem change
    assign irq_req[c] = |(chan_irq_cond[c*quart_pkg::SRC_PER_CHAN +: quart_pkg::SRC_PER_CHAN]
                          & chan_irq_enable[c*quart_pkg::SRC_PER_CHAN +: quart_pkg::SRC_PER_CHAN]); // [R10]

    // Three-state is an enable here; the carrier gives the floating level
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_r[c] <= 1'b0;
        irq_oe_r[c] <= 1'b0;
      end else if (separate) begin
        irq_r[c] <= irq_req[c] && chan_out_enable[c]; // [R9]
        irq_oe_r[c] <= bus.irq_drive_select || chan_out_enable[c]; // [R11] [R12]
      end else begin
        irq_r[c] <= 1'b0;
        irq_oe_r[c] <= 1'b0; // [R13]
      end
    end
  end

  // Open drain: only ever pulls low, an outside pull-up gives the idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_oe_r <= 1'b0;
    end else begin
      irq_n_oe_r <= !separate && (irq_req != '0); // [R17]
    end
  end

  // Every pin output and user strobe comes straight from a flop, except irq_n_out, which is tied low
  assign bus.dev_data = data_r;
  assign bus.dev_data_oe = data_oe_r;
  assign bus.chan_irq = irq_r;
  assign bus.chan_irq_oe = irq_oe_r;
  assign bus.irq_n_out = quart_pkg::IRQ_N_LEVEL;
  assign bus.irq_n_oe = irq_n_oe_r;
  assign chan_wr_stb = wr_stb_r;
  assign chan_rd_stb = rd_stb_r;
  assign chan_reg_idx = idx_r;
  assign chan_wdata = wdata_r;

endmodule // quart_dev_port
`default_nettype wire

// File: quart_host_ctl.sv
// Purpose: Host end: APB-programmed controller that runs quad UART bus cycles
// Assumes: Device samples pins on the same pclk with a short synchroniser
// Notes: One bus cycle at a time; a command written while busy is dropped
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module quart_host_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  quart_bus_if.host bus
);
  typedef enum {H_IDLE, H_SETUP, H_SELECT, H_ACTION, H_RELEASE} hstate_type;

  hstate_type state_r;
  logic [quart_pkg::CNT_W-1:0] cnt_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] cfg_r;
  logic [2:0] idx_r;
  logic [1:0] chan_r;
  logic wr_r;
  logic sum_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [3:0] cs_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic rdy_n_r;
  logic data_oe_r;
  logic [quart_pkg::EV_W-1:0] ev_r;
  logic [quart_pkg::EV_W-1:0] mask_r;
  logic irq_r;
  logic devirq_prev_r;
  logic devirq;
  logic acc;
  logic start;
  logic done;
  logic phase_end;
  logic [31:0] rd_mux;
  logic sep;

  assign acc = psel && penable && pready_r;
  assign start = acc && pwrite && (paddr == quart_pkg::OFS_CMD) && (state_r == H_IDLE);
  assign sep = (cfg_r[quart_pkg::CFG_STYLE] == quart_pkg::STYLE_SEPARATE);
  assign devirq = sep ? (bus.chan_irq_wire != '0) : !bus.irq_n_wire;
  assign phase_end = (cnt_r == '0);
  assign done = (state_r == H_RELEASE) && phase_end;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      quart_pkg::OFS_CFG: rd_mux[1:0] = cfg_r;
      quart_pkg::OFS_STAT: begin
        rd_mux[quart_pkg::ST_BUSY] = (state_r != H_IDLE);
        rd_mux[quart_pkg::ST_DATA_LSB +: 8] = rdata_r;
        rd_mux[quart_pkg::ST_IRQ_LSB +: 4] = bus.chan_irq_wire;
        rd_mux[quart_pkg::ST_IRQ_N] = bus.irq_n_wire;
      end
      quart_pkg::OFS_IRQ_STAT: rd_mux[quart_pkg::EV_W-1:0] = ev_r;
      quart_pkg::OFS_IRQ_MASK: rd_mux[quart_pkg::EV_W-1:0] = mask_r;
      default: rd_mux = '0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && (paddr > quart_pkg::OFS_IRQ_MASK || paddr[1:0] != 2'h0);
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= quart_pkg::CFG_RESET;
      mask_r <= quart_pkg::MASK_RESET;
    end else if (acc && pwrite) begin
      if (paddr == quart_pkg::OFS_CFG) begin
        cfg_r <= pwdata[1:0];
      end
      if (paddr == quart_pkg::OFS_IRQ_MASK) begin
        mask_r <= pwdata[quart_pkg::EV_W-1:0];
      end
    end
  end

  // Sticky events; a new event in the clearing read cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= '0;
      devirq_prev_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      devirq_prev_r <= devirq;
      ev_r <= ((acc && !pwrite && paddr == quart_pkg::OFS_IRQ_STAT) ? '0 : ev_r)
              | {devirq && !devirq_prev_r, done};
      irq_r <= (ev_r & mask_r) != '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= '0;
      chan_r <= '0;
      wr_r <= 1'b0;
      sum_r <= 1'b0;
      wdata_r <= '0;
    end else if (start) begin
      idx_r <= pwdata[quart_pkg::CMD_IDX_LSB +: 3];
      chan_r <= pwdata[quart_pkg::CMD_CHAN_LSB +: 2];
      wr_r <= pwdata[quart_pkg::CMD_WRITE];
      sum_r <= pwdata[quart_pkg::CMD_SUMMARY];
      wdata_r <= pwdata[quart_pkg::CMD_DATA_LSB +: 8];
    end
  end

  // Bus cycle: setup, select low, action edge, hold, release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      cs_n_r <= '1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rdy_n_r <= 1'b1;
      data_oe_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      if (!phase_end) begin
        cnt_r <= cnt_r - 1'b1;
      end
      case (state_r)
        H_IDLE: if (start) begin
          state_r <= H_SETUP;
          cnt_r <= quart_pkg::CNT_W'(quart_pkg::PHASE_CYC - 1);
          data_oe_r <= pwdata[quart_pkg::CMD_WRITE] && !pwdata[quart_pkg::CMD_SUMMARY];
          // Combined mode read parks the shared line low before selecting
          wr_n_r <= sep || pwdata[quart_pkg::CMD_WRITE] || pwdata[quart_pkg::CMD_SUMMARY];
        end
        H_SETUP: if (phase_end) begin
          state_r <= H_SELECT;
          cnt_r <= quart_pkg::CNT_W'(quart_pkg::PHASE_CYC - 1);
          if (!sum_r) begin
            if (sep) begin
              cs_n_r[chan_r] <= 1'b0; // [R4]
            end else begin
              cs_n_r[0] <= 1'b0; // [R1]
            end
          end
        end
        H_SELECT: if (phase_end) begin
          state_r <= H_ACTION;
          cnt_r <= quart_pkg::CNT_W'(quart_pkg::ACTION_CYC - 1);
          if (sum_r) begin
            rdy_n_r <= 1'b0;
          end else if (sep) begin
            rd_n_r <= wr_r;
            wr_n_r <= !wr_r;
          end else begin
            wr_n_r <= !wr_r; // [R18]
          end
        end
        H_ACTION: if (phase_end) begin
          state_r <= H_RELEASE;
          cnt_r <= quart_pkg::CNT_W'(quart_pkg::PHASE_CYC - 1);
          if (!wr_r || sum_r) begin
            rdata_r <= bus.data_bus;
          end
          rd_n_r <= 1'b1;
          // Separate mode: the write strobe ends with the select, never after it
          if (sep) begin
            wr_n_r <= 1'b1;
          end
          rdy_n_r <= 1'b1;
          cs_n_r <= '1;
        end
        H_RELEASE: if (phase_end) begin
          state_r <= H_IDLE;
          wr_n_r <= 1'b1;
          data_oe_r <= 1'b0;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign bus.bus_style = cfg_r[quart_pkg::CFG_STYLE];
  assign bus.irq_drive_select = cfg_r[quart_pkg::CFG_DRIVE];
  assign bus.chan_select_n = cs_n_r;
  assign bus.channel_index_bits = chan_r; // [R2]
  assign bus.register_index_bits = idx_r;
  assign bus.host_read_n = rd_n_r;
  assign bus.host_write_n = wr_n_r;
  assign bus.ready_summary_select_n = rdy_n_r;
  assign bus.host_data = wdata_r; // [R15]
  assign bus.host_data_oe = data_oe_r;

endmodule // quart_host_ctl
`default_nettype wire

// File: quart_bus_assertions.sv
// Purpose: Concurrent checks on the pin bus between host end and device end
// Assumes: One pclk domain, presetn asynchronous active low
// Notes: Sees interface signals only; user-side strobes are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module quart_bus_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_style,
  input wire logic irq_drive_select,
  input wire logic [3:0] chan_select_n,
  input wire logic [2:0] register_index_bits,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic ready_summary_select_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic [3:0] chan_irq_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  logic quiet;
  logic strobing;
  // Weaker than exact, but the synchroniser lag makes an exact figure fragile
  assign quiet = host_read_n && ready_summary_select_n && (bus_style || !host_write_n || chan_select_n[0]);
  assign strobing = !(host_read_n && host_write_n);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  summary_drive_a: assert property (!ready_summary_select_n [*5] |-> dev_data_oe)
    else $error("summary select low but bus not driven");
  bus_release_a: assert property (quiet [*6] |-> !dev_data_oe)
    else $error("data bus driven with no read pending");
  sep_read_drive_a: assert property ((bus_style && !host_read_n && chan_select_n != 4'hF) [*6] |-> dev_data_oe)
    else $error("read strobe held but bus not driven");
  no_contention_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data bus");
  irq_forced_a: assert property ((bus_style && irq_drive_select) [*5] |-> chan_irq_oe == 4'hF)
    else $error("channel interrupts not driven under drive select");
  comb_irq_float_a: assert property (!bus_style [*5] |-> chan_irq_oe == 4'h0)
    else $error("channel interrupt driven in combined mode");
  sep_no_wired_a: assert property (bus_style [*5] |-> !irq_n_oe)
    else $error("shared request pulled in separate mode");
  wr_qualified_a: assert property (bus_style && $fell(host_write_n) |-> host_data_oe && chan_select_n != 4'hF)
    else $error("write strobe without data or select");
  addr_stable_a: assert property (bus_style && strobing && $past(strobing) |-> $stable(register_index_bits)
    && $stable(chan_select_n))
    else $error("index or select moved during strobe");
  irq_n_low_a: assert property (irq_n_oe |-> !irq_n_out && !$past(bus_style, 3))
    else $error("shared request driven high or outside combined mode");
endmodule // quart_bus_assertions
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench joining the host controller to the device port
// Assumes: APB master here, channel cores modelled by random levels
// Notes: Driver queues expected results; a monitor compares them as they appear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [3:0] chan_wr_stb;
  logic [3:0] chan_rd_stb;
  logic [2:0] chan_reg_idx;
  logic [7:0] chan_wdata;
  logic [31:0] chan_rdata;
  logic [3:0] tx_space_flag;
  logic [3:0] rx_avail_flag;
  logic [15:0] chan_irq_cond;
  logic [15:0] chan_irq_enable;
  logic [3:0] chan_out_enable;
  logic [15:0] got;
  logic [63:0] note;
  logic [15:0] strobe_q[$];
  logic [63:0] apb_q[$];
  int fails = 0;
  int total_checks = 0;
  quart_bus_if bus_if ();
  quart_dev_port #(.CHAN(4), .DW(8)) quart_dev_port_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .chan_wr_stb(chan_wr_stb), .chan_rd_stb(chan_rd_stb), .chan_reg_idx(chan_reg_idx), .chan_wdata(chan_wdata),
    .chan_rdata(chan_rdata), .tx_space_flag(tx_space_flag), .rx_avail_flag(rx_avail_flag),
    .chan_irq_cond(chan_irq_cond), .chan_irq_enable(chan_irq_enable), .chan_out_enable(chan_out_enable));
  quart_host_ctl quart_host_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .bus(bus_if));
  quart_bus_assertions quart_bus_assertions_inst (.pclk(pclk), .presetn(presetn), .bus_style(bus_if.bus_style),
    .irq_drive_select(bus_if.irq_drive_select), .chan_select_n(bus_if.chan_select_n),
    .register_index_bits(bus_if.register_index_bits), .host_read_n(bus_if.host_read_n),
    .host_write_n(bus_if.host_write_n), .ready_summary_select_n(bus_if.ready_summary_select_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe), .chan_irq_oe(bus_if.chan_irq_oe),
    .irq_n_out(bus_if.irq_n_out), .irq_n_oe(bus_if.irq_n_oe));
  always #5 pclk = ~pclk;
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb_q.push_back({e, m});
    apb(1'b0, a, 32'h0);
  endtask
  // One bus cycle, then wait for its done interrupt and clear it
  task automatic run(input int ch, input logic [2:0] idx, input logic wr, input logic sum, input logic [7:0] d);
    if (!sum) strobe_q.push_back({wr, 4'(1 << ch), idx, wr ? d : 8'h00});
    apb(1'b1, quart_pkg::OFS_CMD, {16'h0, d, 1'b0, sum, wr, 2'(ch), idx});
    while (irq !== 1'b1) @(posedge pclk);
    reg_rd(quart_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      check(32'(paddr > quart_pkg::OFS_IRQ_MASK), 32'(pslverr));
    end
    if (psel && penable && pready && !pwrite) begin
      note = apb_q.pop_front();
      check(note[63:32] & note[31:0], prdata & note[31:0]);
    end
    if ((chan_wr_stb | chan_rd_stb) != 4'h0) begin
      got = {|chan_wr_stb, chan_wr_stb | chan_rd_stb, chan_reg_idx, (|chan_wr_stb) ? chan_wdata : 8'h00};
      // A pulse with nothing queued is a repeated action on one edge
      if (strobe_q.size() == 0) check(32'h0, {16'h0, got});
      else check({16'h0, strobe_q.pop_front()}, {16'h0, got});
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end
  initial begin
    logic [7:0] d;
    logic [2:0] idx;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chan_rdata = 32'h0;
    tx_space_flag = 4'h0;
    rx_avail_flag = 4'h0;
    chan_irq_cond = 16'h0;
    chan_irq_enable = 16'h0;
    chan_out_enable = 4'h0;
    void'($urandom(32'hAE67E420));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    reg_rd(quart_pkg::OFS_CFG, 32'h1, 32'h3);
    reg_rd(quart_pkg::OFS_IRQ_MASK, 32'h0, 32'h3);
    reg_rd(8'h14, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, quart_pkg::OFS_IRQ_MASK, 32'h1);
    for (int mode = 1; mode >= 0; mode--) begin
      apb(1'b1, quart_pkg::OFS_CFG, 32'(mode));
      for (int ch = 0; ch < 4; ch++) begin
        d = 8'($urandom);
        idx = 3'($urandom);
        chan_rdata <= $urandom;
        tx_space_flag <= 4'($urandom);
        rx_avail_flag <= 4'($urandom);
        run(ch, idx, 1'b1, 1'b0, d);
        run(ch, idx, 1'b0, 1'b0, 8'h00);
        reg_rd(quart_pkg::OFS_STAT, {16'h0, chan_rdata[8*ch +: 8], 8'h0}, 32'h0000FF00);
        run(ch, idx, 1'b0, 1'b1, 8'h00);
        reg_rd(quart_pkg::OFS_STAT, {16'h0, ~rx_avail_flag, ~tx_space_flag, 8'h0}, 32'h0000FF00);
      end
    end
    chan_irq_cond <= 16'hFFFF;
    chan_irq_enable <= 16'h0100;
    // Interrupt settings cross only a register; a style change also crosses the two-flop synchroniser
    repeat (4) @(posedge pclk);
    reg_rd(quart_pkg::OFS_STAT, 32'h0, 32'h001F0000);
    apb(1'b1, quart_pkg::OFS_CFG, 32'h1);
    repeat (4) @(posedge pclk);
    reg_rd(quart_pkg::OFS_STAT, 32'h00100000, 32'h001F0000);
    reg_rd(quart_pkg::OFS_IRQ_STAT, 32'h2, 32'h3);
    apb(1'b1, quart_pkg::OFS_IRQ_MASK, 32'h3);
    for (int s = 0; s < 4; s++) begin
      chan_irq_enable <= 16'h1 << (8 + s);
      chan_out_enable <= 4'h4;
      repeat (4) @(posedge pclk);
      reg_rd(quart_pkg::OFS_STAT, 32'h00140000, 32'h001F0000);
    end
    check(32'h1, {31'h0, irq});
    reg_rd(quart_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
    chan_out_enable <= 4'h0;
    apb(1'b1, quart_pkg::OFS_CFG, 32'h3);
    repeat (4) @(posedge pclk);
    reg_rd(quart_pkg::OFS_STAT, 32'h00100000, 32'h001F0000);
    check(32'h0, {31'h0, irq});
    check(32'h0, 32'(strobe_q.size()));
    close_out();
  end
endmodule // tb_top
`default_nettype wire
